// >>> hdl/radio_seq_pkg.sv
// Contract
// - wake from sleep: 240 us cold, 25 us warm
// - filter tuning during wake, wake irq if enabled
// - listen command in idle enters listen at once
// - idle exit to synth-ready ramps analog regulator, shorter if on
// - synth-ready to listen allowed at any time
// - sleep bit or launch command starts transmission
// - transmitting state and SHR after 16 us
// - PSDU bytes follow SHR in buffer order
// - frame end: tx irq, 32 us back to ready
// - listen command during transmit taken after frame
// - reset bit restores all radio registers
// - reset self-releases after 3 cycles, idle 37 us later
// - sleep bit still set after reset returns to sleep
// - reset from sleep adds oscillator start time unless host clock is radio
// - sleep entered from idle by sleep bit, or after a reset taken in sleep
// - reset leaves pin control bits untouched
// - listen left only by a software command
// - zero frame length aborts the transmission
package radio_seq_pkg;
  // host clock rate and documented times
  localparam int CLK_MHZ = 200;
  localparam int WAKE_COLD_US = 240;
  localparam int WAKE_WARM_US = 25;
  localparam int RAMP_US = 110;
  localparam int ANALOG_REGULATOR_US = 60;
  localparam int TX_LAUNCH_US = 16;
  localparam int TX_RETURN_US = 32;
  localparam int RESET_US = 37;
  localparam int XOSC_START_US = 215;
  localparam int RESET_HOLD_CYC = 3;
  localparam int DLY_W = 20;
  // state command codes
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_FORCE_IDLE = 5'h03;
  localparam logic [4:0] CMD_RX = 5'h06;
  localparam logic [4:0] CMD_IDLE = 5'h08;
  localparam logic [4:0] CMD_PLL = 5'h09;
  // state status codes
  localparam logic [4:0] STS_TX = 5'h02;
  localparam logic [4:0] STS_RX = 5'h06;
  localparam logic [4:0] STS_IDLE = 5'h08;
  localparam logic [4:0] STS_PLL = 5'h09;
  localparam logic [4:0] STS_SLEEP = 5'h0f;
  localparam logic [4:0] STS_PENDING = 5'h1f;
  // synchronisation header and buffer fetch
  localparam logic [7:0] SHR_LEN = 8'h05;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0] SFD_BYTE = 8'ha7;
  localparam logic [1:0] FETCH_CYC = 2'h2;
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h0,
    ST_WAKE = 4'h1,
    ST_IDLE = 4'h2,
    ST_RAMP = 4'h3,
    ST_PLL = 4'h4,
    ST_RX = 4'h5,
    ST_LAUNCH = 4'h6,
    ST_TX = 4'h7,
    ST_RETURN = 4'h8,
    ST_RST_HOLD = 4'h9,
    ST_RST_WAIT = 4'ha
  } seq_state_t;
endpackage

// >>> hdl/delay_timer.sv
`timescale 1ns/1ps
module delay_timer (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // start with a cycle count, pulse when it has run out
  input wire logic load,
  input wire logic [radio_seq_pkg::DLY_W-1:0] count,
  output logic done
);
  logic [radio_seq_pkg::DLY_W-1:0] cnt_reg;
  logic busy_reg;

  // done in the count-th cycle after load
  assign done = busy_reg && (cnt_reg == '0);

  // a new load restarts the count, so an abandoned delay never leaks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (load) begin
      busy_reg <= 1'b1;
      cnt_reg <= count - 1'b1;
    end else if (done) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// >>> hdl/radio_state_sequencer.sv
`timescale 1ns/1ps
module radio_state_sequencer #(
  parameter int CLK_FREQ_MHZ = radio_seq_pkg::CLK_MHZ,
  parameter int WAKE_COLD_CYC = radio_seq_pkg::WAKE_COLD_US * CLK_FREQ_MHZ,
  parameter int WAKE_WARM_CYC = radio_seq_pkg::WAKE_WARM_US * CLK_FREQ_MHZ,
  parameter int RAMP_CYC = radio_seq_pkg::RAMP_US * CLK_FREQ_MHZ,
  parameter int RAMP_SHORT_CYC = (radio_seq_pkg::RAMP_US - radio_seq_pkg::ANALOG_REGULATOR_US) * CLK_FREQ_MHZ,
  parameter int TX_LAUNCH_CYC = radio_seq_pkg::TX_LAUNCH_US * CLK_FREQ_MHZ,
  parameter int TX_RETURN_CYC = radio_seq_pkg::TX_RETURN_US * CLK_FREQ_MHZ,
  parameter int RESET_CYC = radio_seq_pkg::RESET_US * CLK_FREQ_MHZ,
  parameter int XOSC_CYC = radio_seq_pkg::XOSC_START_US * CLK_FREQ_MHZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // software control
  input wire logic sleep_launch_bit,
  input wire logic radio_reset_bit,
  input wire logic cmd_write,
  input wire logic [4:0] state_command_field,
  input wire logic wake_irq_en,
  // system configuration
  input wire logic host_clk_is_radio,
  input wire logic adc_analog_regulator_on,
  // status and events
  output logic [4:0] state_status_field,
  output logic wake_done_irq,
  output logic tx_done_irq,
  output logic regs_default_load,
  // analog block controls
  output logic xosc_en,
  output logic analog_regulator_en,
  output logic ftn_run,
  output logic pll_en,
  output logic pll_tx_freq,
  output logic pa_en,
  output logic rx_en,
  // frame buffer read port, data one cycle after address
  output logic [6:0] buf_addr,
  input wire logic [7:0] buf_rdata,
  // byte stream to modulator
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);
  localparam int DW = radio_seq_pkg::DLY_W;
  // delay loads in host cycles, cut to the timer width on purpose
  localparam logic [DW-1:0] COLD_D = DW'(WAKE_COLD_CYC);
  localparam logic [DW-1:0] WARM_D = DW'(WAKE_WARM_CYC);
  localparam logic [DW-1:0] RAMP_D = DW'(RAMP_CYC);
  localparam logic [DW-1:0] SHORT_D = DW'(RAMP_SHORT_CYC);
  localparam logic [DW-1:0] LAUNCH_D = DW'(TX_LAUNCH_CYC);
  localparam logic [DW-1:0] RETURN_D = DW'(TX_RETURN_CYC);
  localparam logic [DW-1:0] RESET_D = DW'(RESET_CYC);
  localparam logic [DW-1:0] RESET_XOSC_D = DW'(RESET_CYC + XOSC_CYC);
  localparam logic [1:0] HOLD_LAST = 2'(radio_seq_pkg::RESET_HOLD_CYC - 1);
  localparam logic [7:0] SHR_LAST = radio_seq_pkg::SHR_LEN - 8'h01;

  // sequencer state and bookkeeping
  radio_seq_pkg::seq_state_t state_reg;
  radio_seq_pkg::seq_state_t state_next;
  logic slp_prev_reg;
  logic rst_prev_reg;
  logic from_sleep_reg;
  logic rx_pend_reg;
  logic [1:0] hold_cnt_reg;
  logic [1:0] hold_cnt_next;
  // transmit byte path
  logic [7:0] idx_reg;
  logic [6:0] len_reg;
  logic [1:0] fetch_cnt_reg;
  // shared delay timer
  logic timer_load;
  logic timer_done;
  logic [DW-1:0] timer_count;
  // decoded commands and pin edges
  logic slp_rise;
  logic rst_rise;
  logic go_pll;
  logic go_rx;
  logic go_idle;
  logic go_tx;
  logic tx_busy;
  logic enter_reset;
  // byte path decodes
  logic in_tx;
  logic byte_take;
  logic byte_sent;
  logic phr_zero;
  logic frame_end;
  logic [7:0] last_idx;
  // next values of the registered outputs
  logic ana_on;
  logic pll_on;
  logic tx_path;
  logic wake_irq_next;
  logic tx_irq_next;

  // one command code matched against the write strobe
  function automatic logic cmd_is(input logic wr, input logic [4:0] field, input logic [4:0] code);
    return wr && (field == code);
  endfunction

  // status code of a state; every timed step reads as pending
  function automatic logic [4:0] status_of(input radio_seq_pkg::seq_state_t s);
    case (s)
      radio_seq_pkg::ST_SLEEP: return radio_seq_pkg::STS_SLEEP;
      radio_seq_pkg::ST_IDLE: return radio_seq_pkg::STS_IDLE;
      radio_seq_pkg::ST_PLL: return radio_seq_pkg::STS_PLL;
      radio_seq_pkg::ST_RX: return radio_seq_pkg::STS_RX;
      radio_seq_pkg::ST_TX: return radio_seq_pkg::STS_TX;
      default: return radio_seq_pkg::STS_PENDING;
    endcase
  endfunction

  // edge detectors start at the idle level 0, so reset gives no false edge
  assign slp_rise = sleep_launch_bit && !slp_prev_reg;
  assign rst_rise = radio_reset_bit && !rst_prev_reg;
  assign go_pll = cmd_is(cmd_write, state_command_field, radio_seq_pkg::CMD_PLL);
  assign go_rx = cmd_is(cmd_write, state_command_field, radio_seq_pkg::CMD_RX);
  assign go_idle = cmd_is(cmd_write, state_command_field, radio_seq_pkg::CMD_IDLE)
    || cmd_is(cmd_write, state_command_field, radio_seq_pkg::CMD_FORCE_IDLE);
  assign go_tx = cmd_is(cmd_write, state_command_field, radio_seq_pkg::CMD_TX_START) || slp_rise;
  assign tx_busy = (state_reg == radio_seq_pkg::ST_LAUNCH) || (state_reg == radio_seq_pkg::ST_TX)
    || (state_reg == radio_seq_pkg::ST_RETURN);
  assign enter_reset = (state_next == radio_seq_pkg::ST_RST_HOLD) && (state_reg != radio_seq_pkg::ST_RST_HOLD);
  assign hold_cnt_next = (state_reg == radio_seq_pkg::ST_RST_HOLD) ? hold_cnt_reg + 2'h1 : 2'h0;

  // frame bytes: SHR first, then PHR and PSDU from the buffer
  assign in_tx = state_reg == radio_seq_pkg::ST_TX;
  assign last_idx = radio_seq_pkg::SHR_LEN + {1'b0, len_reg};
  assign byte_take = in_tx && !tx_valid && (fetch_cnt_reg == 2'h1);
  assign byte_sent = in_tx && tx_valid && tx_ready;
  assign phr_zero = byte_take && (idx_reg == radio_seq_pkg::SHR_LEN) && (buf_rdata[6:0] == 7'h00);
  assign frame_end = phr_zero || (byte_sent && (idx_reg == last_idx));

  // one timer serves every timed step but the reset hold; a new load restarts it
  delay_timer u_delay_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(timer_load),
    .count(timer_count),
    .done(timer_done)
  );

  // next state; only reset, the sleep bit and the commands leave a steady state
  always_comb begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_count = RESET_D;
    case (state_reg)
      radio_seq_pkg::ST_SLEEP: begin
        if (!sleep_launch_bit) begin
          state_next = radio_seq_pkg::ST_WAKE;
          timer_load = 1'b1;
          timer_count = host_clk_is_radio ? WARM_D : COLD_D;
        end
      end
      radio_seq_pkg::ST_WAKE: begin
        if (timer_done) begin
          state_next = radio_seq_pkg::ST_IDLE;
        end
      end
      radio_seq_pkg::ST_IDLE: begin
        if (sleep_launch_bit) begin
          state_next = radio_seq_pkg::ST_SLEEP;
        end else if (go_rx) begin
          state_next = radio_seq_pkg::ST_RX;
        end else if (go_pll) begin
          state_next = radio_seq_pkg::ST_RAMP;
          timer_load = 1'b1;
          timer_count = adc_analog_regulator_on ? SHORT_D : RAMP_D;
        end
      end
      radio_seq_pkg::ST_RAMP: begin
        if (timer_done) begin
          state_next = radio_seq_pkg::ST_PLL;
        end
      end
      radio_seq_pkg::ST_PLL: begin
        if (go_rx) begin
          state_next = radio_seq_pkg::ST_RX;
        end else if (go_tx) begin
          state_next = radio_seq_pkg::ST_LAUNCH;
          timer_load = 1'b1;
          timer_count = LAUNCH_D;
        end else if (go_idle) begin
          state_next = radio_seq_pkg::ST_IDLE;
        end
      end
      radio_seq_pkg::ST_RX: begin
        if (go_pll) begin
          state_next = radio_seq_pkg::ST_PLL;
        end else if (go_idle) begin
          state_next = radio_seq_pkg::ST_IDLE;
        end
      end
      radio_seq_pkg::ST_LAUNCH: begin
        if (timer_done) begin
          state_next = radio_seq_pkg::ST_TX;
        end
      end
      radio_seq_pkg::ST_TX: begin
        if (frame_end) begin
          state_next = radio_seq_pkg::ST_RETURN;
          timer_load = 1'b1;
          timer_count = RETURN_D;
        end
      end
      radio_seq_pkg::ST_RETURN: begin
        if (timer_done) begin
          state_next = (rx_pend_reg || go_rx) ? radio_seq_pkg::ST_RX : radio_seq_pkg::ST_PLL;
        end
      end
      radio_seq_pkg::ST_RST_HOLD: begin
        if (hold_cnt_reg == HOLD_LAST) begin
          state_next = radio_seq_pkg::ST_RST_WAIT;
          timer_load = 1'b1;
          timer_count = (from_sleep_reg && !host_clk_is_radio) ? RESET_XOSC_D : RESET_D;
        end
      end
      radio_seq_pkg::ST_RST_WAIT: begin
        // pin bits survive the reset, so a set sleep bit sends us back
        if (timer_done) begin
          state_next = (from_sleep_reg && sleep_launch_bit) ? radio_seq_pkg::ST_SLEEP : radio_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = radio_seq_pkg::ST_RST_HOLD;
      end
    endcase
    if (rst_rise && (state_reg != radio_seq_pkg::ST_RST_HOLD)) begin
      state_next = radio_seq_pkg::ST_RST_HOLD;
      timer_load = 1'b0;
    end
  end

  // analog enables follow the state about to be entered
  assign pll_on = (state_next == radio_seq_pkg::ST_PLL) || (state_next == radio_seq_pkg::ST_RX)
    || (state_next == radio_seq_pkg::ST_LAUNCH) || (state_next == radio_seq_pkg::ST_TX)
    || (state_next == radio_seq_pkg::ST_RETURN);
  assign ana_on = (state_next == radio_seq_pkg::ST_RAMP) || pll_on;
  assign tx_path = (state_next == radio_seq_pkg::ST_LAUNCH) || (state_next == radio_seq_pkg::ST_TX);
  assign wake_irq_next = wake_irq_en && (state_next == radio_seq_pkg::ST_IDLE)
    && ((state_reg == radio_seq_pkg::ST_WAKE) || (state_reg == radio_seq_pkg::ST_RST_WAIT));
  assign tx_irq_next = in_tx && frame_end && !phr_zero && (state_next == radio_seq_pkg::ST_RETURN);

  // state, pin edges and the pending receive request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= radio_seq_pkg::ST_RST_HOLD;
      slp_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b0;
      from_sleep_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
      hold_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      slp_prev_reg <= sleep_launch_bit;
      rst_prev_reg <= radio_reset_bit;
      hold_cnt_reg <= hold_cnt_next;
      if (enter_reset) begin
        from_sleep_reg <= state_reg == radio_seq_pkg::ST_SLEEP;
      end
      // cleared before each launch; a request in the same cycle as the clear is not possible
      if (state_reg == radio_seq_pkg::ST_PLL) begin
        rx_pend_reg <= 1'b0;
      end else if (tx_busy && go_rx) begin
        rx_pend_reg <= 1'b1;
      end
    end
  end

  // registered status, events and analog controls
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_status_field <= radio_seq_pkg::STS_PENDING;
      wake_done_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      regs_default_load <= 1'b1;
      xosc_en <= 1'b1;
      analog_regulator_en <= 1'b0;
      ftn_run <= 1'b0;
      pll_en <= 1'b0;
      pll_tx_freq <= 1'b0;
      pa_en <= 1'b0;
      rx_en <= 1'b0;
    end else begin
      state_status_field <= status_of(state_next);
      wake_done_irq <= wake_irq_next;
      tx_done_irq <= tx_irq_next;
      regs_default_load <= state_next == radio_seq_pkg::ST_RST_HOLD;
      xosc_en <= (state_next != radio_seq_pkg::ST_SLEEP) || host_clk_is_radio;
      analog_regulator_en <= ana_on;
      ftn_run <= (state_next == radio_seq_pkg::ST_WAKE) || (state_next == radio_seq_pkg::ST_RST_WAIT);
      pll_en <= pll_on;
      pll_tx_freq <= tx_path;
      pa_en <= tx_path;
      rx_en <= state_next == radio_seq_pkg::ST_RX;
    end
  end

  // byte path: address first, buffer data taken two edges later
  always_ff @(posedge clock) begin
    if (sys_rst || !in_tx) begin
      idx_reg <= 8'h00;
      len_reg <= 7'h00;
      fetch_cnt_reg <= 2'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      buf_addr <= 7'h00;
    end else if (byte_sent) begin
      tx_valid <= 1'b0;
      idx_reg <= idx_reg + 8'h01;
    end else if (!tx_valid) begin
      if (idx_reg < radio_seq_pkg::SHR_LEN) begin
        tx_data <= (idx_reg == SHR_LAST) ? radio_seq_pkg::SFD_BYTE : radio_seq_pkg::PREAMBLE_BYTE;
        tx_valid <= 1'b1;
      end else if (fetch_cnt_reg == 2'h0) begin
        buf_addr <= 7'(idx_reg - radio_seq_pkg::SHR_LEN);
        fetch_cnt_reg <= radio_seq_pkg::FETCH_CYC;
      end else begin
        fetch_cnt_reg <= fetch_cnt_reg - 2'h1;
        if (byte_take && !phr_zero) begin
          tx_data <= buf_rdata;
          tx_valid <= 1'b1;
          if (idx_reg == radio_seq_pkg::SHR_LEN) begin
            len_reg <= buf_rdata[6:0];
          end
        end
      end
    end
  end

  // checks on the sequencing
  property p_listen_at_once;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == radio_seq_pkg::ST_IDLE) && go_rx && !sleep_launch_bit && !rst_rise
      |=> state_status_field == radio_seq_pkg::STS_RX;
  endproperty
  a_listen_at_once: assert property (p_listen_at_once) else $error("listen not entered at once");
  property p_pending_shown;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == radio_seq_pkg::ST_RAMP) || (state_reg == radio_seq_pkg::ST_LAUNCH)
      |-> state_status_field == radio_seq_pkg::STS_PENDING;
  endproperty
  a_pending_shown: assert property (p_pending_shown) else $error("pending code missing");
  property p_sleep_entry;
    @(posedge clock) disable iff (sys_rst)
      (state_next == radio_seq_pkg::ST_SLEEP) && (state_reg != radio_seq_pkg::ST_SLEEP)
      |-> ((state_reg == radio_seq_pkg::ST_IDLE) && sleep_launch_bit)
      || ((state_reg == radio_seq_pkg::ST_RST_WAIT) && from_sleep_reg);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered from wrong state");
  property p_rx_held;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == radio_seq_pkg::ST_RX) && !cmd_write && !rst_rise |=> state_reg == radio_seq_pkg::ST_RX;
  endproperty
  a_rx_held: assert property (p_rx_held) else $error("listen left without command");
  property p_hold_three;
    @(posedge clock) disable iff (sys_rst)
      $rose(regs_default_load) |=> regs_default_load ##1 regs_default_load ##1 !regs_default_load;
  endproperty
  a_hold_three: assert property (p_hold_three) else $error("reset hold not three cycles");
  property p_tx_irq;
    @(posedge clock) disable iff (sys_rst)
      tx_done_irq |-> state_reg == radio_seq_pkg::ST_RETURN;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit event outside frame end");
  property p_abort;
    @(posedge clock) disable iff (sys_rst)
      phr_zero && !rst_rise |=> (state_reg == radio_seq_pkg::ST_RETURN) && !tx_done_irq;
  endproperty
  a_abort: assert property (p_abort) else $error("zero length frame not aborted");
  property p_pa_tx;
    @(posedge clock) disable iff (sys_rst)
      in_tx |-> pa_en && pll_tx_freq;
  endproperty
  a_pa_tx: assert property (p_pa_tx) else $error("amplifier off while sending");
  c_tx_frame: cover property (@(posedge clock) disable iff (sys_rst) tx_done_irq);
  c_wake: cover property (@(posedge clock) disable iff (sys_rst)
    state_reg == radio_seq_pkg::ST_WAKE ##1 state_reg == radio_seq_pkg::ST_IDLE);
  c_abort: cover property (@(posedge clock) disable iff (sys_rst) phr_zero);
  c_pend_rx: cover property (@(posedge clock) disable iff (sys_rst)
    (state_reg == radio_seq_pkg::ST_RETURN) && rx_pend_reg);
endmodule

// >>> verif/radio_state_sequencer_tb.sv
`timescale 1ns/1ps
module radio_state_sequencer_tb;
  logic clock = 0, sys_rst = 1, sleep_launch_bit = 0, radio_reset_bit = 0, cmd_write = 0;
  logic [4:0] state_command_field = 5'h00, state_status_field;
  logic wake_irq_en = 1, adc_analog_regulator_on = 0, tx_ready = 0, wake_done_irq, tx_done_irq, seen = 0;
  logic host_clk_is_radio = 0, zero_len = 0;
  logic [7:0] buf_rdata = 8'h01;
  logic [31:0] seed = 32'h140e00dd;
  int err_total = 0, tests_run = 0;
  // one cycle per microsecond keeps the run brief
  radio_state_sequencer #(.CLK_FREQ_MHZ(1)) u_radio_state_sequencer (
    .clock, .sys_rst, .sleep_launch_bit, .radio_reset_bit, .cmd_write, .state_command_field, .wake_irq_en,
    .host_clk_is_radio, .adc_analog_regulator_on, .state_status_field, .wake_done_irq, .tx_done_irq,
    .regs_default_load(), .xosc_en(), .analog_regulator_en(), .ftn_run(), .pll_en(), .pll_tx_freq(), .pa_en(),
    .rx_en(), .buf_addr(), .buf_rdata, .tx_data(), .tx_valid(), .tx_ready);
  always #2.5 clock = ~clock;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // random stalls; nonzero bytes unless a zero length frame is wanted
  always @(posedge clock) begin
    seed <= xs(seed);
    tx_ready <= seed[0];
    adc_analog_regulator_on <= seed[1];
    buf_rdata <= zero_len ? 8'h00 : (seed[15:8] | 8'h01);
  end
  task automatic chk(logic [4:0] got, logic [4:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_sts(logic [4:0] s, int n);
    repeat (n) begin
      @(negedge clock);
      seen |= tx_done_irq | wake_done_irq;
      if (state_status_field === s) break;
    end
    chk(state_status_field, s);
  endtask
  task automatic cmd(logic [4:0] c);
    @(posedge clock);
    state_command_field <= c;
    cmd_write <= 1;
    @(posedge clock);
    cmd_write <= 0;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 0;
    @(negedge clock);
    chk(state_status_field, radio_seq_pkg::STS_PENDING);
    wait_sts(radio_seq_pkg::STS_IDLE, 200);
    cmd(radio_seq_pkg::CMD_PLL);
    @(negedge clock);
    chk(state_status_field, radio_seq_pkg::STS_PENDING);
    wait_sts(radio_seq_pkg::STS_PLL, 120);
    cmd(radio_seq_pkg::CMD_RX);
    wait_sts(radio_seq_pkg::STS_RX, 4);
    cmd(radio_seq_pkg::CMD_PLL);
    wait_sts(radio_seq_pkg::STS_PLL, 4);
    seen = 0;
    cmd(radio_seq_pkg::CMD_TX_START);
    wait_sts(radio_seq_pkg::STS_TX, 40);
    wait_sts(radio_seq_pkg::STS_PLL, 3000);
    chk({4'h0, seen}, 5'h01);
    @(posedge clock);
    zero_len <= 1;
    seen = 0;
    cmd(radio_seq_pkg::CMD_TX_START);
    wait_sts(radio_seq_pkg::STS_TX, 40);
    wait_sts(radio_seq_pkg::STS_PLL, 200);
    chk({4'h0, seen}, 5'h00);
    @(posedge clock);
    zero_len <= 0;
    cmd(radio_seq_pkg::CMD_TX_START);
    cmd(radio_seq_pkg::CMD_RX);
    wait_sts(radio_seq_pkg::STS_RX, 3000);
    cmd(radio_seq_pkg::CMD_IDLE);
    wait_sts(radio_seq_pkg::STS_IDLE, 4);
    @(posedge clock);
    sleep_launch_bit <= 1;
    wait_sts(radio_seq_pkg::STS_SLEEP, 60);
    seen = 0;
    @(posedge clock);
    sleep_launch_bit <= 0;
    repeat (200) @(negedge clock);
    chk(state_status_field, radio_seq_pkg::STS_PENDING);
    wait_sts(radio_seq_pkg::STS_IDLE, 100);
    chk({4'h0, seen}, 5'h01);
    @(posedge clock);
    host_clk_is_radio <= 1;
    sleep_launch_bit <= 1;
    wait_sts(radio_seq_pkg::STS_SLEEP, 60);
    @(posedge clock);
    sleep_launch_bit <= 0;
    wait_sts(radio_seq_pkg::STS_IDLE, 40);
    @(posedge clock);
    sleep_launch_bit <= 1;
    wait_sts(radio_seq_pkg::STS_SLEEP, 60);
    @(posedge clock);
    radio_reset_bit <= 1;
    repeat (2) @(negedge clock);
    chk(state_status_field, radio_seq_pkg::STS_PENDING);
    wait_sts(radio_seq_pkg::STS_SLEEP, 60);
    @(posedge clock);
    radio_reset_bit <= 0;
    host_clk_is_radio <= 0;
    @(posedge clock);
    radio_reset_bit <= 1;
    sleep_launch_bit <= 0;
    repeat (200) @(negedge clock);
    chk(state_status_field, radio_seq_pkg::STS_PENDING);
    wait_sts(radio_seq_pkg::STS_IDLE, 100);
    end_of_test;
  end
endmodule
